// >>> core/asr_top.sv
// Purpose: serial receiver with wake-up, flags and transmit controls
// Assumes: APB master with zero-wait slave, rxd_pin asynchronous
// Notes: prdata is captured in the setup cycle
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module asr_top #(
  parameter int          ADDR_W   = 8,
  parameter logic [15:0] RATE_RST = asr_pkg::RATE_RST
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // serial line
  input  wire logic              rxd_pin,
  output logic                   txd_pin,
  // interrupt request
  output logic                   irq
);
  if (ADDR_W < 8 || ADDR_W > 16) begin : g_chk
    $error("ADDR_W must lie in 8..16");
  end

  asr_pkg::asr_top_s q;
  asr_pkg::asr_top_s n;
  asr_pkg::asr_evt_s ev;
  asr_pkg::asr_reg_e sel;
  logic              rt_tick;
  logic              bit_tick;
  logic              acc;
  logic              wr2;
  logic              rd_data;
  logic              sleep;
  logic              take;
  logic [7:0]        clr;
  logic [3:0]        flen;
  logic [10:0]       fw;

  localparam asr_pkg::asr_top_s RST_Q = '{
    stat:     asr_pkg::STAT_RST,
    rate_div: RATE_RST,
    txd:      1'b1,
    rxs1:     1'b1,
    rxs2:     1'b1,
    default:  '0
  };

  function automatic asr_pkg::asr_reg_e dec(
    input logic [ADDR_W-1:0] a
  );
    logic [7:0] ix;
    ix = 8'(a >> 2);
    dec = asr_pkg::REG_NONE;
    if (a[1:0] == 2'h0 && (a >> 10) == '0) begin
      case (ix)
        asr_pkg::IDX_RATE: dec = asr_pkg::REG_RATE;
        asr_pkg::IDX_CTL1: dec = asr_pkg::REG_CTL1;
        asr_pkg::IDX_CTL2: dec = asr_pkg::REG_CTL2;
        asr_pkg::IDX_STAT: dec = asr_pkg::REG_STAT;
        asr_pkg::IDX_DATA: dec = asr_pkg::REG_DATA;
        default:           dec = asr_pkg::REG_NONE;
      endcase
    end
  endfunction

  assign sel     = dec(paddr);
  assign acc     = psel && penable;
  assign wr2     = acc && pwrite && sel == asr_pkg::REG_CTL2;
  assign rd_data = acc && !pwrite && sel == asr_pkg::REG_DATA;
  assign sleep   = q.ctl2[asr_pkg::C2_RWU];

  asr_rx_sampler u_smp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .rt_tick (rt_tick),
    .enable  (q.ctl2[asr_pkg::C2_RE]),
    .nine    (q.nine),
    .rxd     (q.rxs2),
    .evt     (ev)
  );

  always_comb begin
    n = q;
    n.rxs1 = rxd_pin;
    n.rxs2 = q.rxs1;
    // 16x timing tick; divisor is software programmable
    rt_tick = (q.rt_cnt >= q.rate_div);
    n.rt_cnt = rt_tick ? 16'h0000 : q.rt_cnt + 16'h0001;
    if (rt_tick) begin
      n.tbit_rt = q.tbit_rt + 4'h1;
    end
    bit_tick = rt_tick && (q.tbit_rt == asr_pkg::RT_LAST);
    flen = q.nine ? asr_pkg::FRAME9 : asr_pkg::FRAME8;

    // read data is frozen in setup so prdata comes from a flop
    if (psel && !penable) begin
      n.rdata = 16'h0000;
      unique case (sel)
        asr_pkg::REG_RATE: n.rdata = q.rate_div;
        asr_pkg::REG_CTL1: begin
          n.rdata[asr_pkg::C1_RX9]  = q.rx9;
          n.rdata[asr_pkg::C1_TX9]  = q.tx9;
          n.rdata[asr_pkg::C1_LEN]  = q.nine;
          n.rdata[asr_pkg::C1_WAKE] = q.wake;
        end
        asr_pkg::REG_CTL2: n.rdata[7:0] = q.ctl2;
        asr_pkg::REG_STAT: n.rdata[7:0] = q.stat;
        asr_pkg::REG_DATA: n.rdata[7:0] = q.rbuf;
        asr_pkg::REG_NONE: n.rdata = 16'h0000;
      endcase
    end

    // clearing sequences first, so a same-cycle set wins
    clr = 8'h00;
    if (rd_data) begin
      clr = q.arm & asr_pkg::ST_RX_MASK;
    end
    if (acc && pwrite && sel == asr_pkg::REG_DATA) begin
      clr = q.arm & asr_pkg::ST_TX_MASK;
    end
    n.stat = q.stat & ~clr;
    n.arm = q.arm & ~clr;
    if (acc && !pwrite && sel == asr_pkg::REG_STAT) begin
      n.arm = q.rdata[7:0];
    end

    // receive side
    take = 1'b0;
    if (ev.addr_mark && sleep && q.wake) begin
      n.ctl2[asr_pkg::C2_RWU] = 1'b0;
    end
    if (ev.idle_hit && sleep && !q.wake) begin
      n.ctl2[asr_pkg::C2_RWU] = 1'b0;
    end
    if (ev.idle_hit && !sleep) begin
      n.stat[asr_pkg::ST_IDLE] = 1'b1;
    end
    if (ev.char_done && !sleep) begin
      if (n.stat[asr_pkg::ST_RECEIVE_FULL_FLAG]) begin
        // new character is dropped, framing result not reported
        n.stat[asr_pkg::ST_OR] = 1'b1;
      end else if (!n.stat[asr_pkg::ST_FE]) begin
        take = 1'b1;
        n.rbuf = ev.data[7:0];
        if (q.nine) begin
          n.rx9 = ev.data[8];
        end
        n.stat[asr_pkg::ST_RECEIVE_FULL_FLAG] = 1'b1;
        if (ev.ferr) begin
          n.stat[asr_pkg::ST_FE] = 1'b1;
        end
        if (ev.noise) begin
          n.stat[asr_pkg::ST_NF] = 1'b1;
        end
      end
    end

    // transmit side: frame word is stop, data, start, LSB first
    fw = q.nine ? {1'b1, q.tx9, q.tbuf, 1'b0}
                : {2'b11, q.tbuf, 1'b0};
    if (bit_tick) begin
      if (q.tleft != 4'h0) begin
        n.txd = q.tshift[0];
        n.tshift = {1'b1, q.tshift[10:1]};
        n.tleft = q.tleft - 4'h1;
      end else if (q.ctl2[asr_pkg::C2_TE] && q.pre_q) begin
        n.pre_q = 1'b0;
        n.txd = 1'b1;
        n.tshift = 11'h7FF;
        n.tleft = flen - 4'h1;
        n.tx_busy = 1'b1;
      end else if (q.ctl2[asr_pkg::C2_TE] &&
                   (q.brk_q || q.ctl2[asr_pkg::C2_SBK])) begin
        n.brk_q = 1'b0;
        n.txd = 1'b0;
        n.tshift = 11'h000;
        n.tleft = flen - 4'h1;
        n.tx_busy = 1'b1;
      end else if (q.ctl2[asr_pkg::C2_TE] && q.tfull) begin
        n.tfull = 1'b0;
        n.stat[asr_pkg::ST_TX_BUFFER_EMPTY_FLAG] = 1'b1;
        n.txd = fw[0];
        n.tshift = {1'b1, fw[10:1]};
        n.tleft = flen - 4'h1;
        n.tx_busy = 1'b1;
      end else begin
        n.txd = 1'b1;
        n.tx_busy = 1'b0;
        if (q.tx_busy) begin
          n.stat[asr_pkg::ST_TC] = 1'b1;
        end
        if (!q.ctl2[asr_pkg::C2_TE] && q.tfull) begin
          // disabled transmitter drops a waiting character
          n.tfull = 1'b0;
          n.stat[asr_pkg::ST_TX_BUFFER_EMPTY_FLAG] = 1'b1;
        end
      end
    end

    // register writes last; a software write to sleep wins
    if (acc && pwrite) begin
      unique case (sel)
        asr_pkg::REG_RATE: n.rate_div = pwdata[15:0];
        asr_pkg::REG_CTL1: begin
          n.tx9  = pwdata[asr_pkg::C1_TX9];
          n.nine = pwdata[asr_pkg::C1_LEN];
          n.wake = pwdata[asr_pkg::C1_WAKE];
        end
        asr_pkg::REG_CTL2: begin
          n.ctl2 = pwdata[7:0];
          if (pwdata[asr_pkg::C2_TE] && !q.ctl2[asr_pkg::C2_TE]) begin
            n.pre_q = 1'b1;
          end
          if (pwdata[asr_pkg::C2_SBK]) begin
            n.brk_q = 1'b1;
          end
        end
        asr_pkg::REG_DATA: begin
          n.tbuf = pwdata[7:0];
          n.tfull = 1'b1;
        end
        asr_pkg::REG_STAT: n.tbuf = q.tbuf;
        asr_pkg::REG_NONE: n.tbuf = q.tbuf;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= RST_Q;
    end else begin
      q <= n;
    end
  end

  assign prdata  = {16'h0000, q.rdata};
  assign pready  = 1'b1;
  assign pslverr = acc && sel == asr_pkg::REG_NONE;
  assign txd_pin = q.txd;
  assign irq = (q.ctl2[asr_pkg::C2_TIE] & q.stat[asr_pkg::ST_TX_BUFFER_EMPTY_FLAG]) |
               (q.ctl2[asr_pkg::C2_TX_DONE_IRQ_EN] & q.stat[asr_pkg::ST_TC]) |
               (q.ctl2[asr_pkg::C2_RIE] &
                (q.stat[asr_pkg::ST_RECEIVE_FULL_FLAG] | q.stat[asr_pkg::ST_OR])) |
               (q.ctl2[asr_pkg::C2_QUIET_LINE_IRQ_EN] & q.stat[asr_pkg::ST_IDLE]);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_mark;
    ev.addr_mark && sleep && q.wake && !wr2;
  endsequence

  sequence s_quiet;
    ev.idle_hit && sleep && !q.wake && !wr2;
  endsequence

  sequence s_full_hit;
    ev.char_done && !sleep && q.stat[asr_pkg::ST_RECEIVE_FULL_FLAG] && clr == 8'h00;
  endsequence

  property p_sleep_mute;
    sleep |=> !$rose(q.stat[asr_pkg::ST_RECEIVE_FULL_FLAG]) &&
              !$rose(q.stat[asr_pkg::ST_IDLE]);
  endproperty
  a_sleep_mute: assert property (p_sleep_mute)
    else $error("flag set while asleep");

  property p_quiet_wake;
    s_quiet |=> !sleep;
  endproperty
  a_quiet_wake: assert property (p_quiet_wake)
    else $error("quiet line did not wake receiver");

  property p_mark_wake;
    s_mark |=> !sleep ##0 !ev.char_done;
  endproperty
  a_mark_wake: assert property (p_mark_wake)
    else $error("address mark did not wake before stop");

  property p_overrun;
    s_full_hit |=> q.stat[asr_pkg::ST_OR] && $stable(q.rbuf);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun lost buffer or flag");

  property p_or_hides_fe;
    s_full_hit |=> $stable(q.stat[asr_pkg::ST_FE]);
  endproperty
  a_or_hides_fe: assert property (p_or_hides_fe)
    else $error("framing error reported with overrun");

  property p_take;
    take |=> q.stat[asr_pkg::ST_RECEIVE_FULL_FLAG] &&
      q.stat[asr_pkg::ST_FE] == $past(ev.ferr) &&
      (q.stat[asr_pkg::ST_NF] || !$past(ev.noise));
  endproperty
  a_take: assert property (p_take)
    else $error("flags not set with receive full");

  property p_fe_block;
    q.stat[asr_pkg::ST_FE] && clr == 8'h00 |=> $stable(q.rbuf);
  endproperty
  a_fe_block: assert property (p_fe_block)
    else $error("buffer changed under framing error");

  property p_or_clear;
    rd_data && q.arm[asr_pkg::ST_OR] && !ev.char_done
      |=> !q.stat[asr_pkg::ST_OR];
  endproperty
  a_or_clear: assert property (p_or_clear)
    else $error("overrun not cleared by data read");

  property p_preamble;
    wr2 && pwdata[asr_pkg::C2_TE] && !q.ctl2[asr_pkg::C2_TE]
      |=> q.pre_q;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("preamble not queued");

  property p_break;
    wr2 && pwdata[asr_pkg::C2_SBK] |=> q.brk_q;
  endproperty
  a_break: assert property (p_break)
    else $error("break not queued");

  property p_load;
    bit_tick && q.tleft == 4'h0 && q.ctl2[asr_pkg::C2_TE] &&
      q.tfull && !q.pre_q && !q.brk_q && !q.ctl2[asr_pkg::C2_SBK]
      && !(acc && pwrite && sel == asr_pkg::REG_DATA)
      |=> q.stat[asr_pkg::ST_TX_BUFFER_EMPTY_FLAG] && !q.txd && !q.tfull;
  endproperty
  a_load: assert property (p_load)
    else $error("load did not start frame or set empty");
endmodule // asr_top
`default_nettype wire

// >>> common/asr_pkg.sv
// Purpose: shared constants and types of the serial receiver block
// Assumes: one 200 MHz clock, registers reached over APB
// Notes: a register's byte address is four times its index
package asr_pkg;
  // register indices
  localparam logic [7:0] IDX_RATE = 8'h2B;
  localparam logic [7:0] IDX_CTL1 = 8'h2C;
  localparam logic [7:0] IDX_CTL2 = 8'h2D;
  localparam logic [7:0] IDX_STAT = 8'h2E;
  localparam logic [7:0] IDX_DATA = 8'h2F;
  // serial_control_one fields
  localparam int C1_RX9  = 32'h7;
  localparam int C1_TX9  = 32'h6;
  localparam int C1_LEN  = 32'h4;
  localparam int C1_WAKE = 32'h3;
  // serial_control_two fields
  localparam int C2_TIE  = 32'h7;
  localparam int C2_TX_DONE_IRQ_EN = 32'h6;
  localparam int C2_RIE  = 32'h5;
  localparam int C2_QUIET_LINE_IRQ_EN = 32'h4;
  localparam int C2_TE   = 32'h3;
  localparam int C2_RE   = 32'h2;
  localparam int C2_RWU  = 32'h1;
  localparam int C2_SBK  = 32'h0;
  // serial_status fields
  localparam int ST_TX_BUFFER_EMPTY_FLAG = 32'h7;
  localparam int ST_TC   = 32'h6;
  localparam int ST_RECEIVE_FULL_FLAG = 32'h5;
  localparam int ST_IDLE = 32'h4;
  localparam int ST_OR   = 32'h3;
  localparam int ST_NF   = 32'h2;
  localparam int ST_FE   = 32'h1;
  localparam logic [7:0] ST_RX_MASK = 8'h3E;
  localparam logic [7:0] ST_TX_MASK = 8'hC0;
  localparam logic [7:0] STAT_RST   = 8'hC0;
  // timing
  localparam logic [15:0] RATE_RST = 16'h0033;
  localparam logic [3:0]  RT_LAST  = 4'hF;
  localparam logic [3:0]  SMP_A    = 4'h7;
  localparam logic [3:0]  SMP_B    = 4'h8;
  localparam logic [3:0]  SMP_C    = 4'h9;
  localparam logic [3:0]  FRAME8   = 4'hA;
  localparam logic [3:0]  FRAME9   = 4'hB;

  typedef enum logic [0:0] {
    RXM_IDLE = 1'h0,
    RXM_BUSY = 1'h1
  } asr_rxm_e;

  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_RATE = 3'h1,
    REG_CTL1 = 3'h2,
    REG_CTL2 = 3'h3,
    REG_STAT = 3'h4,
    REG_DATA = 3'h5
  } asr_reg_e;

  typedef struct packed {
    logic       char_done;
    logic [8:0] data;
    logic       noise;
    logic       ferr;
    logic       addr_mark;
    logic       idle_hit;
  } asr_evt_s;

  typedef struct packed {
    asr_rxm_e   mode;
    logic [3:0] rt;
    logic [3:0] idx;
    logic [1:0] smp;
    logic [8:0] data;
    logic       noise;
    logic [7:0] quiet;
    logic       quiet_done;
    asr_evt_s   evt;
  } asr_smp_s;

  typedef struct packed {
    logic        rxs1;
    logic        rxs2;
    logic [15:0] rt_cnt;
    logic [15:0] rate_div;
    logic [3:0]  tbit_rt;
    logic        tx9;
    logic        nine;
    logic        wake;
    logic        rx9;
    logic [7:0]  ctl2;
    logic [7:0]  stat;
    logic [7:0]  arm;
    logic [7:0]  rbuf;
    logic [15:0] rdata;
    logic [7:0]  tbuf;
    logic        tfull;
    logic [10:0] tshift;
    logic [3:0]  tleft;
    logic        pre_q;
    logic        brk_q;
    logic        tx_busy;
    logic        txd;
  } asr_top_s;
endpackage

// >>> core/asr_rx_sampler.sv
// Purpose: bit recovery and character framing of the receive line
// Assumes: rxd already synchronised, rt_tick at 16x bit rate
// Notes: events are one-cycle pulses from flops
`timescale 1ns/1ps
`default_nettype none
module asr_rx_sampler (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // timing and control
  input  wire logic             rt_tick,
  input  wire logic             enable,
  input  wire logic             nine,
  // line and events
  input  wire logic             rxd,
  output asr_pkg::asr_evt_s     evt
);
  asr_pkg::asr_smp_s q;
  asr_pkg::asr_smp_s n;
  logic [2:0] votes;
  logic       bit_v;
  logic       odd;
  logic [3:0] last;
  logic [3:0] flen;

  always_comb begin
    n = q;
    n.evt = '0;
    votes = {q.smp, rxd};
    bit_v = (votes[0] & votes[1]) | (votes[0] & votes[2]) |
            (votes[1] & votes[2]);
    odd = (|votes) & ~(&votes);
    flen = nine ? asr_pkg::FRAME9 : asr_pkg::FRAME8;
    last = flen - 4'h1;
    if (!enable) begin
      n.mode = asr_pkg::RXM_IDLE;
      n.quiet = 8'h00;
      n.quiet_done = 1'b0;
    end else if (rt_tick) begin
      unique case (q.mode)
        asr_pkg::RXM_IDLE: begin
          if (!rxd) begin
            n.mode = asr_pkg::RXM_BUSY;
            n.rt = 4'h1;
            n.idx = 4'h0;
            n.noise = 1'b0;
            n.data = 9'h000;
            n.quiet = 8'h00;
            n.quiet_done = 1'b0;
          end else if (!q.quiet_done) begin
            if (q.quiet == {flen, 4'h0}) begin
              n.evt.idle_hit = 1'b1;
              n.quiet_done = 1'b1;
            end else begin
              n.quiet = q.quiet + 8'h01;
            end
          end
        end
        asr_pkg::RXM_BUSY: begin
          n.rt = q.rt + 4'h1;
          if (q.rt == asr_pkg::SMP_A || q.rt == asr_pkg::SMP_B) begin
            n.smp = {q.smp[0], rxd};
          end
          if (q.rt == asr_pkg::SMP_C) begin
            n.idx = q.idx + 4'h1;
            n.noise = q.noise | odd;
            if (q.idx == 4'h0 && bit_v) begin
              // a start bit that votes high was a glitch
              n.mode = asr_pkg::RXM_IDLE;
            end else if (q.idx == last) begin
              n.evt.char_done = 1'b1;
              n.evt.data = q.data;
              n.evt.noise = q.noise | odd;
              n.evt.ferr = ~bit_v;
              n.mode = asr_pkg::RXM_IDLE;
            end else if (q.idx != 4'h0) begin
              n.data[q.idx - 4'h1] = bit_v;
              if (q.idx == last - 4'h1 && bit_v) begin
                n.evt.addr_mark = 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '{mode: asr_pkg::RXM_IDLE, default: '0};
    end else begin
      q <= n;
    end
  end

  assign evt = q.evt;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_start;
    enable && rt_tick && q.mode == asr_pkg::RXM_IDLE && !rxd
      |=> q.mode == asr_pkg::RXM_BUSY && q.rt == 4'h1;
  endproperty
  a_start: assert property (p_start)
    else $error("start edge not taken");

  property p_noise;
    enable && rt_tick && q.mode == asr_pkg::RXM_BUSY &&
      q.rt == asr_pkg::SMP_C && odd |=> q.noise || q.evt.noise;
  endproperty
  a_noise: assert property (p_noise)
    else $error("sample disagreement not seen as noise");
endmodule // asr_rx_sampler
`default_nettype wire

// >>> tb/asr_line_model.sv
// Purpose: far-end sender that puts serial frames on the receive line
// Assumes: rt tick every clock, so one bit lasts BIT_CLKS clocks
// Notes: a glitch inverts one clock in mid data bit 0 to provoke noise
`timescale 1ns/1ps
`default_nettype none
module asr_line_model #(
  parameter int BIT_CLKS = 16
) (
  // clock
  input  wire logic       clk_sys,
  // frame request
  input  wire logic       send,
  input  wire logic [8:0] data,
  input  wire logic       nine,
  input  wire logic       bad_stop,
  input  wire logic       glitch,
  // status and line
  output logic            busy,
  output logic            rxd
);
  logic [10:0] frm;
  int          nb;
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (send) begin
        busy <= 1'b1;
        // start zero, data lsb first, stop one
        frm = nine ? {~bad_stop, data, 1'b0}
                   : {1'b1, ~bad_stop, data[7:0], 1'b0};
        nb = nine ? 11 : 10;
        // bits of one frame follow with no idle gap
        for (int i = 0; i < nb; i++) begin
          for (int c = 0; c < BIT_CLKS; c++) begin
            rxd <= (glitch && i == 1 && c == 8) ? ~frm[i] : frm[i];
            @(posedge clk_sys);
          end
        end
        // released line idles high
        rxd <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule // asr_line_model
`default_nettype wire

// >>> tb/asr_top_tb_top.sv
// Purpose: self-checking bench of the serial receiver over APB
// Assumes: divisor 0, so one rt tick per clock and 16 clocks a bit
// Notes: quiet bit is masked except where it is the subject and in the status rst, asleep and rx off checks
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
  n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, a); end end
module asr_top_tb_top;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic        txd_pin, irq, se, send, nine, bad_stop, glitch, busy, rxd;
  logic [7:0]  paddr;
  logic [8:0]  data;
  logic [31:0] pwdata, prdata, rv;
  int          n_mismatch = 0;
  int          n_compared = 0;

  asr_top #(.ADDR_W(8), .RATE_RST(16'h0000)) dut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_pin(rxd),
    .txd_pin(txd_pin), .irq(irq));
  asr_line_model #(.BIT_CLKS(16)) far (
    .clk_sys(clk_sys), .send(send), .data(data), .nine(nine),
    .bad_stop(bad_stop), .glitch(glitch), .busy(busy), .rxd(rxd));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 8'h00);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
  endtask

  task automatic st(input logic [7:0] m, input logic [7:0] e, input string nm);
    rd(asr_pkg::IDX_STAT);
    `CHK(nm, e, rv[7:0] & m)
  endtask

  task automatic frame(input logic [8:0] d, input logic nn, input logic bs,
                       input logic gl);
    @(posedge clk_sys);
    send <= 1'b1;
    data <= d;
    nine <= nn;
    bad_stop <= bs;
    glitch <= gl;
    do @(posedge clk_sys); while (busy !== 1'b1);
    send <= 1'b0;
    do @(posedge clk_sys); while (busy !== 1'b0);
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic t_regs;
    st(8'hFF, 8'hC0, "status rst");
    rd(asr_pkg::IDX_CTL2);
    `CHK("ctl2 rst", 8'h00, rv[7:0])
    rd(8'h10);
    `CHK("slverr", 1'b1, se)
    `CHK("unmapped", 32'h00000000, rv)
    wr(asr_pkg::IDX_CTL2, 8'h24);
    rd(asr_pkg::IDX_CTL2);
    `CHK("ctl2 rw", 8'h24, rv[7:0])
  endtask

  task automatic t_basic;
    `CHK("irq idle", 1'b0, irq)
    frame(9'h0A5, 1'b0, 1'b0, 1'b0);
    st(8'hEF, 8'hE0, "rx full");
    `CHK("irq", 1'b1, irq)
    rd(asr_pkg::IDX_DATA);
    `CHK("rx data", 8'hA5, rv[7:0])
    st(8'hEF, 8'hC0, "full clr");
    `CHK("irq off", 1'b0, irq)
    repeat (200) @(posedge clk_sys);
    st(8'h10, 8'h10, "quiet");
    rd(asr_pkg::IDX_DATA);
    repeat (200) @(posedge clk_sys);
    st(8'h10, 8'h00, "quiet once");
  endtask

  task automatic t_errors;
    frame(9'h05A, 1'b0, 1'b0, 1'b1);
    st(8'hEF, 8'hE4, "noise");
    rd(asr_pkg::IDX_DATA);
    `CHK("voted data", 8'h5A, rv[7:0])
    frame(9'h03C, 1'b0, 1'b1, 1'b0);
    st(8'hEF, 8'hE2, "framing");
    rd(asr_pkg::IDX_DATA);
    st(8'h2E, 8'h00, "fe clr");
    frame(9'h011, 1'b0, 1'b0, 1'b0);
    frame(9'h022, 1'b0, 1'b1, 1'b0);
    rd(asr_pkg::IDX_DATA);
    `CHK("kept data", 8'h11, rv[7:0])
    st(8'hEF, 8'hE8, "overrun");
    rd(asr_pkg::IDX_DATA);
    st(8'h2E, 8'h00, "or clr");
  endtask

  task automatic t_nine;
    wr(asr_pkg::IDX_CTL1, 8'h10);
    frame(9'h1A5, 1'b1, 1'b0, 1'b0);
    rd(asr_pkg::IDX_CTL1);
    `CHK("ninth", 1'b1, rv[7])
    st(8'hEF, 8'hE0, "nine full");
    rd(asr_pkg::IDX_DATA);
    `CHK("nine data", 8'hA5, rv[7:0])
    wr(asr_pkg::IDX_CTL1, 8'h00);
  endtask

  task automatic t_sleep;
    wr(asr_pkg::IDX_CTL2, 8'h06);
    wr(asr_pkg::IDX_CTL2, 8'h04);
    rd(asr_pkg::IDX_CTL2);
    `CHK("sw wake", 8'h04, rv[7:0])
    wr(asr_pkg::IDX_CTL2, 8'h06);
    frame(9'h055, 1'b0, 1'b0, 1'b0);
    st(8'h3E, 8'h00, "asleep");
    repeat (200) @(posedge clk_sys);
    rd(asr_pkg::IDX_CTL2);
    `CHK("quiet wake", 8'h04, rv[7:0])
    wr(asr_pkg::IDX_CTL1, 8'h08);
    wr(asr_pkg::IDX_CTL2, 8'h06);
    frame(9'h012, 1'b0, 1'b0, 1'b0);
    st(8'h2E, 8'h00, "mark asleep");
    frame(9'h093, 1'b0, 1'b0, 1'b0);
    rd(asr_pkg::IDX_CTL2);
    `CHK("mark wake", 8'h04, rv[7:0])
    st(8'h2E, 8'h20, "mark rx");
    rd(asr_pkg::IDX_DATA);
    `CHK("mark data", 8'h93, rv[7:0])
    wr(asr_pkg::IDX_CTL1, 8'h00);
  endtask

  task automatic t_off;
    wr(asr_pkg::IDX_CTL2, 8'h00);
    frame(9'h077, 1'b0, 1'b0, 1'b0);
    st(8'h3E, 8'h00, "rx off");
  endtask

  // far-end receiver on txd_pin: waits for the start bit, then takes
  // one mid-bit sample per bit; w counts the clocks spent waiting
  task automatic tx_grab(input int nb, output logic [10:0] f,
                         output int w);
    f = 11'h000;
    w = 0;
    while (txd_pin !== 1'b0 && w < 600) begin
      @(posedge clk_sys);
      w++;
    end
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i <= nb + 1; i++) begin
      f[i] = txd_pin;
      repeat (16) @(posedge clk_sys);
    end
  endtask

  task automatic t_tx;
    logic [10:0] f;
    int          w;
    wr(asr_pkg::IDX_CTL2, 8'h08);
    st(8'hC0, 8'hC0, "tx flags");
    wr(asr_pkg::IDX_DATA, 8'hA5);
    st(8'hC0, 8'h00, "tx clr");
    rd(asr_pkg::IDX_DATA);
    `CHK("rx kept", 8'h93, rv[7:0])
    // without the idle preamble the start bit would come within 16 clocks
    tx_grab(8, f, w);
    `CHK("preamble", 1'b1, w > 100)
    `CHK("tx frame", {1'b1, 8'hA5, 1'b0}, f[9:0])
    st(8'hC0, 8'hC0, "tx done");
    wr(asr_pkg::IDX_CTL1, 8'h50);
    wr(asr_pkg::IDX_DATA, 8'h3C);
    tx_grab(9, f, w);
    `CHK("tx nine", {2'b11, 8'h3C, 1'b0}, f)
    wr(asr_pkg::IDX_CTL1, 8'h00);
    wr(asr_pkg::IDX_CTL2, 8'h09);
    wr(asr_pkg::IDX_CTL2, 8'h08);
    tx_grab(8, f, w);
    `CHK("break", 10'h000, f[9:0])
    `CHK("break end", 1'b1, txd_pin)
    wr(asr_pkg::IDX_CTL2, 8'h00);
  endtask

  task automatic tally_and_finish;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // span is over ten times the thirteen frames plus quiet-line waits
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, send, nine, bad_stop, glitch} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    data = 9'h000;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_basic;
    t_errors;
    t_nine;
    t_sleep;
    t_off;
    t_tx;
    tally_and_finish;
  end
endmodule // asr_top_tb_top
`default_nettype wire
